// file: common/ssd_pkg.sv
// Shared constants for the stepper serial register port and stall monitor
package ssd_pkg;
    localparam int          WORD_BITS       = 16;
    localparam logic [4:0]  WORD_COUNT      = 5'h10;
    // Address field values (two top bits)
    localparam logic [1:0]  ADDR_SETUP_A    = 2'h0;
    localparam logic [1:0]  ADDR_SETUP_B    = 2'h1;
    localparam logic [1:0]  ADDR_RUN        = 2'h2;
    localparam logic [1:0]  ADDR_PROFILE    = 2'h3;
    // Power-on values including address bits
    localparam logic [15:0] RST_SETUP_A     = 16'h271c;
    localparam logic [15:0] RST_SETUP_B     = 16'h5020;
    localparam logic [15:0] RST_RUN         = 16'h8a40;
    localparam logic [15:0] RST_PROFILE     = 16'hc045;
    // Field positions
    localparam int          CD_LSB          = 2;
    localparam int          CD_MSB          = 9;
    localparam int          SRC_LO_BIT      = 0;
    localparam int          SRC_HI_BIT      = 1;
    localparam int          STS_LSB         = 12;
    localparam int          STS_MSB         = 13;
    localparam logic [1:0]  STS_OPPOSITE    = 2'h0;
    localparam logic [1:0]  STS_SAME        = 2'h1;
    // Upper flag positions in both fault words
    localparam int          BIT_ANY_FAULT   = 15;
    localparam int          BIT_STALL       = 10;
    // Controller-side APB register offsets
    localparam logic [7:0]  OFS_TX          = 8'h00;
    localparam logic [7:0]  OFS_CTRL        = 8'h04;
    localparam logic [7:0]  OFS_STATUS      = 8'h08;
    localparam logic [7:0]  OFS_RX          = 8'h0c;
    localparam logic [7:0]  OFS_DIV         = 8'h10;
    localparam logic [7:0]  RST_DIV         = 8'h06;
endpackage

// file: common/ssd_link_if.sv
// Serial link between controller and driver device
`timescale 1ns/10ps
`default_nettype none
interface ssd_link_if;
    logic sclk;
    logic strobe_n;
    logic serial_in_pin;
    logic serial_out_pin;
    logic serial_out_oe;
    modport device (input sclk, input strobe_n, input serial_in_pin,
                    output serial_out_pin, output serial_out_oe);
    modport ctrl (output sclk, output strobe_n, output serial_in_pin,
                  input serial_out_pin, input serial_out_oe);
endinterface
`default_nettype wire

// file: hdl/ssd_device.sv
// Driver-side serial register port with PWM-count stall monitor
//
// Notes on behaviour
// - Scheme select 00 compares opposite phases, default.
// - One PWM cycle counter per phase during rise.
// - Opposite scheme: compare with other phase's previous count.
// - Scheme 01: compare with same phase's previous count.
// - Stall source selected: pin low while stall set.
// - Phase A PWM-on selectable onto fault pin.
// - Strobe high between transfers; no shifting then.
// - Sample serial input on rising clock, strobe low.
// - Controller sends sixteen bits, MSB first.
// - Strobe rise latches word, applies new settings.
// - Good write clears the fault and stall flags of both fault words.
// - Threshold is setup word B bits 9..2, default 8.
// - Reset loads the four listed default words.
// - Works with defaults, no transfer ever needed.
// - Each device gets its own strobe line.
// - Top two bits select the target register.
// - Wrong bit count: discard, keep faults, set flag if any bits came.
// - Shift out angle word for setup B, else short.
// - Both fault words share the upper eight flags.
`timescale 1ns/10ps
`default_nettype none
module ssd_device
    import ssd_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Serial link
    ssd_link_if.device       link,
    // Motor-side events
    input  wire logic        pwm_cycle,
    input  wire logic [1:0]  rise_start,
    input  wire logic [1:0]  rise_end,
    input  wire logic        pwm_on_a,
    input  wire logic [7:0]  status_flags,
    input  wire logic [7:0]  short_flags,
    input  wire logic [5:0]  step_angle,
    // Outputs
    output logic             fault_output_pin,
    output logic [15:0]      system_setup_a,
    output logic [15:0]      system_setup_b,
    output logic [15:0]      motion_run,
    output logic [15:0]      profile_load,
    output logic             stall_flag
);
    logic [1:0]  sclk_s;
    logic [1:0]  str_s;
    logic [1:0]  sdi_s;
    logic        sclk_d;
    logic        str_d;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [4:0]  edge_cnt;
    logic [15:0] short_fault_word;
    logic [15:0] angle_fault_word;
    logic        any_fault_flag;
    logic [7:0]  pwm_cnt [2];
    logic [7:0]  prev_cnt [2];
    logic [1:0]  prev_valid;
    logic [7:0]  upper_flags;

    wire sclk_rise = sclk_s[1] & ~sclk_d;
    wire str_fall  = ~str_s[1] & str_d;
    wire str_rise  = str_s[1] & ~str_d;
    wire good_word = (edge_cnt == WORD_COUNT);
    wire [7:0] count_difference_threshold = system_setup_b[CD_MSB:CD_LSB];
    wire [1:0] stall_scheme_select = profile_load[STS_MSB:STS_LSB];
    wire pin_source_select_hi = system_setup_b[SRC_HI_BIT];
    wire pin_source_select_lo = system_setup_b[SRC_LO_BIT];

    function automatic logic [7:0] abs_diff(input logic [7:0] a, input logic [7:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // Link pins come from another domain
    always_ff @(posedge core_clk)
    begin
        sclk_s <= {sclk_s[0], link.sclk};
        str_s  <= {str_s[0], link.strobe_n};
        sdi_s  <= {sdi_s[0], link.serial_in_pin};
        sclk_d <= sclk_s[1];
        str_d  <= str_s[1];
    end

    // Shift in, count edges
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            shift_in <= 16'h0000;
            edge_cnt <= 5'h00;
        end
        else if (str_fall)
        begin
            edge_cnt <= 5'h00;
        end
        else if (!str_s[1] && sclk_rise)
        begin
            shift_in <= {shift_in[14:0], sdi_s[1]};
            if (edge_cnt != 5'h1f)
                edge_cnt <= edge_cnt + 5'h01;
        end
    end

    // Writable registers
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            system_setup_a <= RST_SETUP_A;
            system_setup_b <= RST_SETUP_B;
            motion_run     <= RST_RUN;
            profile_load   <= RST_PROFILE;
        end
        else if (str_rise && good_word)
        begin
            case (shift_in[15:14])
                ADDR_SETUP_A: system_setup_a <= shift_in;
                ADDR_SETUP_B: system_setup_b <= shift_in;
                ADDR_RUN:     motion_run     <= shift_in;
                default:      profile_load   <= shift_in;
            endcase
        end
    end

    // Per-phase PWM counters and stall compare
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pwm_cnt[0]  <= 8'h00;
            pwm_cnt[1]  <= 8'h00;
            prev_cnt[0] <= 8'h00;
            prev_cnt[1] <= 8'h00;
            prev_valid  <= 2'h0;
            stall_flag  <= 1'b0;
        end
        else
        begin
            for (int p = 0; p < 2; p++)
            begin
                if (rise_start[p])
                    pwm_cnt[p] <= 8'h00;
                else if (pwm_cycle && pwm_cnt[p] != 8'hff)
                    pwm_cnt[p] <= pwm_cnt[p] + 8'h01;
                if (rise_end[p])
                begin
                    prev_cnt[p]   <= pwm_cnt[p];
                    prev_valid[p] <= 1'b1;
                end
            end
            for (int p = 0; p < 2; p++)
            begin
                if (rise_end[p])
                begin
                    if (stall_scheme_select == STS_OPPOSITE && prev_valid[1-p]
                        && abs_diff(pwm_cnt[p], prev_cnt[1-p])
                           > count_difference_threshold)
                        stall_flag <= 1'b1;
                    if (stall_scheme_select == STS_SAME && prev_valid[p]
                        && abs_diff(pwm_cnt[p], prev_cnt[p])
                           > count_difference_threshold)
                        stall_flag <= 1'b1;
                end
            end
            // Set wins: clear only when no phase ends a rise this cycle
            if (str_rise && good_word && rise_end == 2'h0)
                stall_flag <= 1'b0;
        end
    end

    // Fault words; events set, good write clears, bad write flags
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            any_fault_flag <= 1'b1;
        else if (str_rise && !good_word && edge_cnt != 5'h00)
            any_fault_flag <= 1'b1;
        // A stall that this very write clears must not re-arm the flag
        else if (|short_flags || |status_flags || (stall_flag && !(str_rise && good_word)))
            any_fault_flag <= 1'b1;
        else if (str_rise && good_word)
            any_fault_flag <= 1'b0;
    end

    always_comb
    begin
        upper_flags = {any_fault_flag, status_flags[6:3], stall_flag, status_flags[1:0]};
        short_fault_word = {upper_flags, short_flags};
        angle_fault_word = {upper_flags, 2'h0, step_angle};
    end

    // Serial output: present flag at strobe fall, then shift the chosen word
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            shift_out          <= 16'h0000;
            link.serial_out_pin <= 1'b0;
            link.serial_out_oe  <= 1'b0;
        end
        else if (str_s[1])
        begin
            link.serial_out_oe  <= 1'b0;
        end
        else if (str_fall)
        begin
            link.serial_out_oe  <= 1'b1;
            link.serial_out_pin <= any_fault_flag;
            shift_out          <= short_fault_word;
        end
        else if (sclk_rise)
        begin
            // Upper bytes agree, so the word can be picked once both address bits are in
            if (edge_cnt == 5'h01 && {shift_in[0], sdi_s[1]} == ADDR_SETUP_B)
            begin
                link.serial_out_pin <= angle_fault_word[13];
                shift_out           <= {angle_fault_word[13:0], 2'h0};
            end
            else
            begin
                link.serial_out_pin <= shift_out[14];
                shift_out           <= {shift_out[14:0], 1'b0};
            end
        end
    end

    // Fault output pin: active low for any fault or for stall, or phase A PWM-on, per source select
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            fault_output_pin <= 1'b1;
        else if (pin_source_select_hi && !pin_source_select_lo)
            fault_output_pin <= pwm_on_a;
        else if (pin_source_select_hi && pin_source_select_lo)
            fault_output_pin <= ~stall_flag;
        else
            fault_output_pin <= ~any_fault_flag;
    end
endmodule
`default_nettype wire

// file: hdl/ssd_ctrl.sv
// Controller end: APB slave that runs one 16-bit strobe-framed transfer
`timescale 1ns/10ps
`default_nettype none
module ssd_ctrl
    import ssd_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    ssd_link_if.ctrl         link
);
    typedef enum logic [3:0] {
        SSC_IDLE  = 4'b0001,
        SSC_LOW   = 4'b0010,
        SSC_HIGH  = 4'b0100,
        SSC_END   = 4'b1000
    } ssc_state_t;

    ssc_state_t  state;
    logic [15:0] tx_word;
    logic [15:0] rx_word;
    logic [7:0]  div;
    logic [7:0]  div_cnt;
    logic [4:0]  bits;
    logic        start;
    logic [1:0]  sdo_s;

    wire wr_acc = psel && penable && pwrite;
    wire tick   = (div_cnt == 8'h00);

    always_ff @(posedge core_clk)
        sdo_s <= {sdo_s[0], link.serial_out_pin};

    // APB: zero wait states
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            tx_word <= 16'h0000;
            div     <= RST_DIV;
            start   <= 1'b0;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            start   <= 1'b0;
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                case (paddr)
                    OFS_TX:     prdata <= {16'h0, tx_word};
                    OFS_STATUS: prdata <= {31'h0, state != SSC_IDLE};
                    OFS_RX:     prdata <= {16'h0, rx_word};
                    OFS_DIV:    prdata <= {24'h0, div};
                    OFS_CTRL:   prdata <= 32'h0;
                    default:
                    begin
                        prdata  <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
            if (wr_acc && pready)
            begin
                case (paddr)
                    OFS_TX:   tx_word <= pwdata[15:0];
                    OFS_DIV:  div     <= pwdata[7:0];
                    OFS_CTRL: start   <= pwdata[0] && state == SSC_IDLE;
                    default:  start   <= 1'b0;
                endcase
            end
        end
    end

    // Link sequencer: clock idles high, data changes on falling edge
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state              <= SSC_IDLE;
            div_cnt            <= 8'h00;
            bits               <= 5'h00;
            rx_word            <= 16'h0000;
            link.sclk          <= 1'b1;
            link.strobe_n      <= 1'b1;
            link.serial_in_pin <= 1'b0;
        end
        else
        begin
            div_cnt <= tick ? div : div_cnt - 8'h01;
            case (state)
                SSC_IDLE:
                    if (start)
                    begin
                        link.strobe_n <= 1'b0;
                        bits          <= 5'h00;
                        div_cnt       <= div;
                        state         <= SSC_LOW;
                    end
                SSC_LOW:
                    if (tick)
                    begin
                        link.sclk          <= 1'b0;
                        link.serial_in_pin <= tx_word[4'hf - bits[3:0]];
                        state              <= SSC_HIGH;
                    end
                SSC_HIGH:
                    if (tick)
                    begin
                        link.sclk <= 1'b1;
                        rx_word   <= {rx_word[14:0], sdo_s[1]};
                        bits      <= bits + 5'h01;
                        state     <= (bits == WORD_COUNT - 5'h01) ? SSC_END : SSC_LOW;
                    end
                SSC_END:
                    if (tick)
                    begin
                        link.strobe_n <= 1'b1;
                        state         <= SSC_IDLE;
                    end
                default:
                    state <= SSC_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: tb/ssd_link_asserts.sv
// Protocol checker for the serial link between controller and driver
`timescale 1ns/10ps
`default_nettype none
module ssd_link_asserts (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Link signals
    input  wire logic sclk,
    input  wire logic strobe_n,
    input  wire logic serial_in_pin,
    input  wire logic serial_out_pin,
    input  wire logic serial_out_oe
);
    logic       sclk_q;
    logic [4:0] edges;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge core_clk)
    begin
        sclk_q <= sclk;
    end
    // Rising link-clock edges in the open frame; saturates so overruns stay visible
    always_ff @(posedge core_clk)
    begin
        if (sys_rst || strobe_n)
            edges <= 5'h00;
        else if (sclk && !sclk_q && edges != 5'h1f)
            edges <= edges + 5'h01;
    end
    sequence s_open; $fell(strobe_n) ##0 sclk; endsequence
    sequence s_close; ##[32:1000] $rose(strobe_n); endsequence
    property p_rst_idle; $fell(sys_rst) |-> strobe_n && sclk; endproperty
    property p_clk_quiet; $fell(sclk) |-> !strobe_n; endproperty
    property p_sdi_stable; $rose(sclk) |-> $stable(serial_in_pin) && !strobe_n; endproperty
    property p_sixteen; $rose(strobe_n) |-> edges == 5'h10; endproperty
    property p_close_high; $rose(strobe_n) |-> sclk; endproperty
    property p_frame; s_open |-> s_close; endproperty
    property p_oe_on; !strobe_n [*6] |-> serial_out_oe; endproperty
    property p_oe_off; strobe_n [*6] |-> !serial_out_oe; endproperty
    property p_start_high; $fell(strobe_n) |-> sclk; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("link not idle after reset");
    a_clk_quiet: assert property (p_clk_quiet) else $error("clock moved outside frame");
    a_sdi_stable: assert property (p_sdi_stable) else $error("data moved at clock rise");
    a_sixteen: assert property (p_sixteen) else $error("frame edge count not 16");
    a_close_high: assert property (p_close_high) else $error("strobe rose with clock low");
    a_frame: assert property (p_frame) else $error("frame length out of range");
    a_oe_on: assert property (p_oe_on) else $error("serial out not driven in frame");
    a_oe_off: assert property (p_oe_off) else $error("serial out driven while idle");
    a_start_high: assert property (p_start_high) else $error("frame opened with clock low");
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench: controller and driver joined, second driver fed by bench
`timescale 1ns/10ps
`default_nettype none
module testbench
    import ssd_pkg::*;
;
    localparam int HALF = 6;
    logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, status_flags, short_flags;
    logic [31:0] pwdata, prdata, rd, rs;
    logic        pwm_cycle, pwm_on_a, pin, b_pin, stall_flag, first;
    logic [1:0]  rise_start, rise_end;
    logic [5:0]  step_angle;
    logic [15:0] dv [4];
    logic [15:0] bv [4];
    logic [15:0] w;
    int          fail_count, n_checks, cyc, st, ff, sch, cd;
    int          cnt [2];
    int          have [2];
    ssd_link_if lk ();
    ssd_link_if lk2 ();
    ssd_ctrl u_ssd_ctrl (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .link(lk.ctrl));
    ssd_device u_ssd_device (.core_clk, .sys_rst, .link(lk.device), .pwm_cycle, .rise_start,
        .rise_end, .pwm_on_a, .status_flags, .short_flags, .step_angle, .fault_output_pin(pin),
        .system_setup_a(dv[0]), .system_setup_b(dv[1]), .motion_run(dv[2]),
        .profile_load(dv[3]), .stall_flag);
    ssd_device u_ssd_device_b (.core_clk, .sys_rst, .link(lk2.device), .pwm_cycle,
        .rise_start, .rise_end, .pwm_on_a, .status_flags, .short_flags, .step_angle,
        .fault_output_pin(b_pin), .system_setup_a(bv[0]), .system_setup_b(bv[1]),
        .motion_run(bv[2]), .profile_load(bv[3]), .stall_flag());
    ssd_link_asserts u_ssd_link_asserts (.core_clk, .sys_rst, .sclk(lk.sclk),
        .strobe_n(lk.strobe_n), .serial_in_pin(lk.serial_in_pin),
        .serial_out_pin(lk.serial_out_pin), .serial_out_oe(lk.serial_out_oe));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            final_report();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // Whole transfer through the controller, with the model's fault word compared
    task xfer(input logic [15:0] d);
        logic [15:0] e;
        e = {ff[0], 4'h0, st[0], 2'h0, d[15:14] == ADDR_SETUP_B ? {2'h0, step_angle} : 8'h00};
        apb(1'b1, OFS_TX, {16'h0, d});
        apb(1'b1, OFS_CTRL, 32'h1);
        rd = 32'h1;
        while (rd[0] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0);
        apb(1'b0, OFS_RX, 32'h0);
        if (first) chk("rx ff", 1, rd[15]);
        else chk("rx", e, rd[15:0]);
        first = 0;
        ff = 0;
        st = 0;
        if (d[15:14] == ADDR_SETUP_B) cd = d[9:2];
        if (d[15:14] == ADDR_PROFILE) sch = d[13:12];
        repeat (4) @(posedge core_clk);
        chk("reg", d, dv[d[15:14]]);
        chk("stall clr", 0, stall_flag);
    endtask
    task rise(input int p, input int n);
        int r;
        r = sch == 0 ? 1 - p : p;
        rise_start[p] <= 1'b1;
        @(posedge core_clk);
        rise_start <= 2'b00;
        repeat (n)
        begin
            pwm_cycle <= 1'b1;
            @(posedge core_clk);
            pwm_cycle <= 1'b0;
            @(posedge core_clk);
        end
        rise_end[p] <= 1'b1;
        @(posedge core_clk);
        rise_end <= 2'b00;
        if (have[r] != 0 && (n > cnt[r] ? n - cnt[r] : cnt[r] - n) > cd) st = 1;
        if (st != 0) ff = 1;
        cnt[p] = n;
        have[p] = 1;
        repeat (5) @(posedge core_clk);
        chk("stall", st, stall_flag);
        chk("pin stall", st == 0, pin);
    endtask
    // Bench plays controller on the second link, with chosen bit counts
    task bang(input int n, input logic [15:0] d);
        lk2.strobe_n <= 1'b0;
        repeat (HALF) @(posedge core_clk);
        for (int i = 0; i < n; i++)
        begin
            lk2.sclk <= 1'b0;
            lk2.serial_in_pin <= d[15 - (i % 16)];
            repeat (HALF) @(posedge core_clk);
            lk2.sclk <= 1'b1;
            // Periods alternate 120 and 130 ns, 125 ns on average
            repeat (HALF + i % 2) @(posedge core_clk);
        end
        lk2.strobe_n <= 1'b1;
        lk2.serial_in_pin <= ~lk2.serial_in_pin;
        repeat (12) @(posedge core_clk);
    endtask
    initial
    begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {pwm_cycle, pwm_on_a, rise_start, rise_end, status_flags, short_flags} = 22'h0;
        {lk2.sclk, lk2.strobe_n, lk2.serial_in_pin} = 3'b110;
        // Counters start at zero; model fault flag starts set, threshold at 8
        ff = 1;
        cd = 8;
        first = 1'b1;
        rs = 32'h2;
        step_angle = 6'h0;
        cnt = '{0, 0};
        have = '{0, 0};
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        step_angle <= 6'(rnd());
        @(posedge core_clk);
        chk("rst a", RST_SETUP_A, dv[0]);
        chk("rst b", RST_SETUP_B, dv[1]);
        chk("rst run", RST_RUN, dv[2]);
        chk("rst prof", RST_PROFILE, dv[3]);
        apb(1'b0, OFS_DIV, 32'h0);
        chk("div", RST_DIV, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", 1, err);
        chk("unmapped", 0, rd);
        $display("test reset done");
        foreach (cnt[k])
        begin
            w = {2'b00, 14'(rnd())};
            bang(16, w);
            chk("b reg", w, bv[0]);
            chk("b pin", 1, b_pin);
            bang(k == 0 ? 5 : 17, {2'b00, ~w[13:0]});
            chk("b keep", w, bv[0]);
            chk("b ff", 0, b_pin);
        end
        $display("test framing faults done");
        for (int a = 0; a < 4; a++) xfer({a[1:0], 14'(rnd())});
        apb(1'b1, OFS_DIV, 32'h2);
        xfer(16'h5023);
        xfer(RST_PROFILE);
        $display("test register writes done");
        rise(0, 10);
        rise(1, 18);
        rise(0, 27);
        xfer(RST_RUN);
        xfer(16'hd045);
        rise(1, 18);
        rise(0, 18);
        $display("test stall done");
        xfer(16'h5022);
        for (int v = 0; v < 2; v++)
        begin
            pwm_on_a <= v[0];
            repeat (4) @(posedge core_clk);
            chk("pin pwm", v, pin);
        end
        $display("test pin source done");
        final_report();
    end
endmodule
`default_nettype wire
